// [rtl/tsgps_map.vh]
`ifndef TSGPS_MAP_VH
`define TSGPS_MAP_VH
// ----------------------------------------
// register byte offsets (word aligned)
// ----------------------------------------
`define TSGPS_OFS_CTRL 8'h00
`define TSGPS_OFS_GPS_STATUS 8'h04
`define TSGPS_OFS_DILUTION 8'h08
`define TSGPS_OFS_DILUTION_MAX 8'h0C
`define TSGPS_OFS_SECONDS 8'h10
`define TSGPS_OFS_YEAR 8'h14
`define TSGPS_OFS_IRQ_STATUS 8'h18
`define TSGPS_OFS_IRQ_MASK 8'h1C
// ----------------------------------------
// control register fields
// ----------------------------------------
`define TSGPS_CTRL_MODE_LSB 0
`define TSGPS_CTRL_MODE_MSB 1
`define TSGPS_CTRL_RESEED_BIT 8
// ----------------------------------------
// primary input selections
// ----------------------------------------
`define TSGPS_MODE_RTC 2'h0
`define TSGPS_MODE_GPS 2'h1
`define TSGPS_MODE_IRIG_9X 2'h2
`define TSGPS_MODE_IRIG_04 2'h3
// ----------------------------------------
// status word fields
// ----------------------------------------
`define TSGPS_STAT_LOCK_BIT 15
`define TSGPS_STAT_DOP_BIT 11
`define TSGPS_STAT_VIEW_MSB 7
`define TSGPS_STAT_VIEW_LSB 4
`define TSGPS_STAT_USED_MSB 3
`define TSGPS_STAT_USED_LSB 0
// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define TSGPS_IRQ_PPS 0
`define TSGPS_IRQ_LOCK 1
`define TSGPS_IRQ_DOP 2
`define TSGPS_IRQ_LOAD 3
`define TSGPS_IRQ_W 4
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define TSGPS_RST_MODE 2'h0
`define TSGPS_RST_DILUTION_MAX 16'h0005
`define TSGPS_RST_YEAR 8'h00
`define TSGPS_CLK_HZ 40000000
`define TSGPS_HZ_PER_MHZ 1000000
`define TSGPS_PPS_WIDTH_US 1000
`define TSGPS_YEAR_UNITS_LSB 0
`define TSGPS_YEAR_TENS_LSB 5
`define TSGPS_HTRANS_NONSEQ_BIT 1
`endif

// [rtl/tsgps_top.v]
`timescale 1ns/100ps
`include "tsgps_map.vh"

// Operation
// - selecting the real-time clock as primary input loads the seed time from the battery-backed clock.
// - in real-time-clock mode GPS and IRIG time is ignored even when those sources are active.
// - the lock flag at bit 15 of the status word resets to zero and is one only once the receiver has lock.
// - bit 11 of the status word is one whenever the dilution figures are outside their accepted range.
// - bits 7 to 4 report satellites in view and bits 3 to 0 satellites in use.
// - the actual dilution figure is readable in its own register apart from the status word.
// - the pulse-per-second output comes from internal time, once a second, whatever the source.
// - with the 2004 IRIG revision the year is decoded from the control function bits; 9x gives no year.
module tsgps_top #(
    parameter TICKS_PER_SEC = `TSGPS_CLK_HZ,
    parameter PPS_WIDTH = `TSGPS_CLK_HZ / `TSGPS_HZ_PER_MHZ * `TSGPS_PPS_WIDTH_US
) (
    input wire CLK, // system clock, 40 MHz
    input wire NRST, // async reset, active low
    input wire HSEL, // slave select
    input wire [31:0] HADDR, // byte address
    input wire [1:0] HTRANS, // transfer type
    input wire HWRITE, // write when high
    input wire [2:0] HSIZE, // transfer size, word only
    input wire [31:0] HWDATA, // write data
    input wire HREADY, // bus ready
    output wire HREADYOUT, // slave ready, always high
    output wire HRESP, // always okay
    output reg [31:0] HRDATA, // read data
    output wire IRQ, // level interrupt
    input wire [31:0] RTC_SECONDS, // battery-backed clock seconds
    input wire [31:0] GPS_SECONDS, // receiver time of next second
    input wire GPS_TIME_VALID, // pulse, receiver time is fresh
    input wire GPS_LOCK, // receiver has position lock
    input wire [15:0] GPS_DILUTION, // receiver dilution figure
    input wire [3:0] GPS_SATS_VIEW, // satellites in view
    input wire [3:0] GPS_SATS_USED, // satellites in use
    input wire [31:0] IRIG_SECONDS, // decoded irig time
    input wire [17:0] IRIG_CONTROL_FUNCTION_BITS, // decoded control function field
    input wire IRIG_FRAME_VALID, // pulse, irig frame decoded
    output reg PPS_OUT, // once-per-second pulse
    output reg [31:0] TIME_SECONDS // internal seconds count
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // bcd digit pair to binary, clamps junk digits at nine
    function [7:0] bcd_to_bin;
        input [3:0] tens;
        input [3:0] units;
        reg [3:0] t;
        reg [3:0] u;
        begin
            t = (tens > 4'h9) ? 4'h9 : tens;
            u = (units > 4'h9) ? 4'h9 : units;
            bcd_to_bin = {t, 3'h0} + {2'h0, t, 1'b0} + {4'h0, u};
        end
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [1:0] mode_reg;
    reg [15:0] dil_max_reg;
    reg [7:0] year_reg;
    reg [`TSGPS_IRQ_W-1:0] irq_stat_reg;
    reg [`TSGPS_IRQ_W-1:0] irq_mask_reg;
    reg [15:0] status_reg;
    reg [15:0] dil_reg;
    reg seed_pend_reg;
    reg [31:0] sub_reg;
    reg [31:0] sec_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    reg lock_d_reg;
    reg dop_d_reg;

    wire addr_phase = HSEL & HREADY & HTRANS[`TSGPS_HTRANS_NONSEQ_BIT];
    wire [7:0] ofs = HADDR[7:0];
    wire wr_ctrl = wr_pend_reg & (wr_addr_reg == `TSGPS_OFS_CTRL);
    wire wr_irq_stat = wr_pend_reg & (wr_addr_reg == `TSGPS_OFS_IRQ_STATUS);

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // ----------------------------------------
    // bus slave, zero wait states
    // ----------------------------------------
    // write address held into the data phase, read data latched at address phase
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            HRDATA <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= addr_phase & HWRITE;
            wr_addr_reg <= ofs;
            if (addr_phase & ~HWRITE) begin
                case (ofs)
                    `TSGPS_OFS_CTRL: HRDATA <= {30'h0, mode_reg};
                    `TSGPS_OFS_GPS_STATUS: HRDATA <= {16'h0, status_reg};
                    `TSGPS_OFS_DILUTION: HRDATA <= {16'h0, dil_reg};
                    `TSGPS_OFS_DILUTION_MAX: HRDATA <= {16'h0, dil_max_reg};
                    `TSGPS_OFS_SECONDS: HRDATA <= sec_reg;
                    `TSGPS_OFS_YEAR: HRDATA <= {24'h0, year_reg};
                    `TSGPS_OFS_IRQ_STATUS: HRDATA <= {28'h0, irq_stat_reg};
                    `TSGPS_OFS_IRQ_MASK: HRDATA <= {28'h0, irq_mask_reg};
                    default: HRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software-writable settings; status and dilution have no write path
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_reg <= `TSGPS_RST_MODE;
            dil_max_reg <= `TSGPS_RST_DILUTION_MAX;
            irq_mask_reg <= {`TSGPS_IRQ_W{1'b0}};
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                `TSGPS_OFS_CTRL: mode_reg <= HWDATA[`TSGPS_CTRL_MODE_MSB:`TSGPS_CTRL_MODE_LSB];
                `TSGPS_OFS_DILUTION_MAX: dil_max_reg <= HWDATA[15:0];
                `TSGPS_OFS_IRQ_MASK: irq_mask_reg <= HWDATA[`TSGPS_IRQ_W-1:0];
                default: mode_reg <= mode_reg;
            endcase
        end
    end

    // ----------------------------------------
    // receiver status
    // ----------------------------------------
    wire dop_bad = GPS_DILUTION > dil_max_reg;

    // status word rebuilt each cycle; lock reads zero from reset until receiver locks
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            status_reg <= 16'h0000;
            dil_reg <= 16'h0000;
        end else begin
            status_reg <= 16'h0000;
            status_reg[`TSGPS_STAT_LOCK_BIT] <= GPS_LOCK;
            status_reg[`TSGPS_STAT_DOP_BIT] <= dop_bad;
            status_reg[`TSGPS_STAT_VIEW_MSB:`TSGPS_STAT_VIEW_LSB] <= GPS_SATS_VIEW;
            status_reg[`TSGPS_STAT_USED_MSB:`TSGPS_STAT_USED_LSB] <= GPS_SATS_USED;
            dil_reg <= GPS_DILUTION;
        end
    end

    // ----------------------------------------
    // time source selection
    // ----------------------------------------
    wire in_rtc = (mode_reg == `TSGPS_MODE_RTC);
    wire in_irig = (mode_reg == `TSGPS_MODE_IRIG_9X) | (mode_reg == `TSGPS_MODE_IRIG_04);
    // external loads only outside rtc mode
    wire gps_load = (mode_reg == `TSGPS_MODE_GPS) & GPS_TIME_VALID & GPS_LOCK;
    wire irig_load = in_irig & IRIG_FRAME_VALID;
    // a seed comes after reset, on entry to rtc mode, or on software request
    wire seed_req = wr_ctrl & ((HWDATA[`TSGPS_CTRL_MODE_MSB:`TSGPS_CTRL_MODE_LSB] == `TSGPS_MODE_RTC)
                    | HWDATA[`TSGPS_CTRL_RESEED_BIT]);
    wire rtc_load = seed_pend_reg & in_rtc;
    wire ext_load = gps_load | irig_load | rtc_load;
    wire sec_tick = (sub_reg == TICKS_PER_SEC - 1);

    // seed pending flag; reset sets it so the counter starts from the clock
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            seed_pend_reg <= 1'b1;
        end else if (seed_req) begin
            seed_pend_reg <= 1'b1;
        end else if (rtc_load) begin
            seed_pend_reg <= 1'b0;
        end
    end

    // internal time base; a load realigns the second boundary to the source
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sub_reg <= 32'h0000_0000;
            sec_reg <= 32'h0000_0000;
        end else if (rtc_load) begin
            sub_reg <= 32'h0000_0000;
            sec_reg <= RTC_SECONDS;
        end else if (gps_load) begin
            sub_reg <= 32'h0000_0000;
            sec_reg <= GPS_SECONDS;
        end else if (irig_load) begin
            sub_reg <= 32'h0000_0000;
            sec_reg <= IRIG_SECONDS;
        end else if (sec_tick) begin
            sub_reg <= 32'h0000_0000;
            sec_reg <= sec_reg + 32'h0000_0001;
        end else begin
            sub_reg <= sub_reg + 32'h0000_0001;
        end
    end

    // pulse free-runs from internal time whatever the source, even with none attached
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            PPS_OUT <= 1'b0;
            TIME_SECONDS <= 32'h0000_0000;
        end else begin
            PPS_OUT <= (sub_reg < PPS_WIDTH);
            TIME_SECONDS <= sec_reg;
        end
    end

    // ----------------------------------------
    // year
    // ----------------------------------------
    // only the 2004 revision carries year; 9x keeps the software year
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            year_reg <= `TSGPS_RST_YEAR;
        end else if (irig_load & (mode_reg == `TSGPS_MODE_IRIG_04)) begin
            year_reg <= bcd_to_bin(IRIG_CONTROL_FUNCTION_BITS[`TSGPS_YEAR_TENS_LSB+3:`TSGPS_YEAR_TENS_LSB],
                IRIG_CONTROL_FUNCTION_BITS[`TSGPS_YEAR_UNITS_LSB+3:`TSGPS_YEAR_UNITS_LSB]);
        end else if (wr_pend_reg & (wr_addr_reg == `TSGPS_OFS_YEAR)) begin
            year_reg <= HWDATA[7:0];
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            lock_d_reg <= 1'b0;
            dop_d_reg <= 1'b0;
        end else begin
            lock_d_reg <= status_reg[`TSGPS_STAT_LOCK_BIT];
            dop_d_reg <= status_reg[`TSGPS_STAT_DOP_BIT];
        end
    end

    wire [`TSGPS_IRQ_W-1:0] irq_evt = {ext_load,
        status_reg[`TSGPS_STAT_DOP_BIT] & ~dop_d_reg,
        status_reg[`TSGPS_STAT_LOCK_BIT] & ~lock_d_reg,
        sec_tick};
    wire [`TSGPS_IRQ_W-1:0] irq_clr = wr_irq_stat ? HWDATA[`TSGPS_IRQ_W-1:0] : {`TSGPS_IRQ_W{1'b0}};

    // sticky bits; a new event in the clearing cycle wins over the clear
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            irq_stat_reg <= {`TSGPS_IRQ_W{1'b0}};
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
        end
    end

    assign IRQ = |(irq_stat_reg & irq_mask_reg);

endmodule // tsgps_top

// [sim/tsgps_sva.sv]
`timescale 1ns/100ps
module tsgps_sva #(
    parameter int TICKS_PER_SEC = 100
) (
    input wire CLK, // clock
    input wire NRST, // reset
    input wire HSEL, // select
    input wire [31:0] HADDR, // address
    input wire [1:0] HTRANS, // type
    input wire HWRITE, // write
    input wire [31:0] HWDATA, // wdata
    input wire HREADY, // ready in
    input wire HREADYOUT, // ready out
    input wire HRESP, // response
    input wire [31:0] HRDATA, // rdata
    input wire PPS_OUT, // pulse
    input wire [31:0] TIME_SECONDS, // time
    input wire [31:0] RTC_SECONDS, // rtc
    input wire GPS_LOCK, // lock
    input wire [15:0] GPS_DILUTION, // dop
    input wire [3:0] GPS_SATS_VIEW, // view
    input wire [3:0] GPS_SATS_USED // used
);
default clocking cb @(posedge CLK); endclocking
default disable iff (!NRST);
// ----
// bus shadow
// ----
reg rd_q;
reg wc_q;
reg [7:0] ad_q;
reg [1:0] mode_q;
// mode copy so time checks know when outside sources are locked out
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        rd_q <= 1'b0;
        wc_q <= 1'b0;
        ad_q <= 8'h00;
        mode_q <= 2'h0;
    end else begin
        rd_q <= HSEL && HREADY && HTRANS[1] && !HWRITE;
        wc_q <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:0] == 8'h00;
        ad_q <= HADDR[7:0];
        if (wc_q) begin
            mode_q <= HWDATA[1:0];
        end
    end
end
wire st_rd = rd_q && ad_q == 8'h04;
a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus not ready or not okay");
a_rtc_hold: assert property ($changed(TIME_SECONDS) && mode_q == 2'h0 |->
    TIME_SECONDS == $past(TIME_SECONDS) + 32'h1 || TIME_SECONDS == RTC_SECONDS) else $error("foreign time in rtc");
a_pps_hold: assert property ($rose(PPS_OUT) |-> PPS_OUT [*8]) else $error("pulse too short");
a_pps_gap: assert property ($fell(PPS_OUT) |-> ##[1:TICKS_PER_SEC] $rose(PPS_OUT)) else $error("pulse missing");
a_lock_flag: assert property (st_rd |-> HRDATA[15] == $past(GPS_LOCK, 2)) else $error("lock flag wrong");
a_sat_counts: assert property (st_rd |-> HRDATA[7:0] == {$past(GPS_SATS_VIEW, 2), $past(GPS_SATS_USED, 2)})
    else $error("satellite counts wrong");
a_spare_zero: assert property (st_rd |-> {HRDATA[31:16], HRDATA[14:12], HRDATA[10:8]} == 22'h0)
    else $error("spare status bits set");
a_dop_read: assert property (rd_q && ad_q == 8'h08 |-> HRDATA == {16'h0, $past(GPS_DILUTION, 2)})
    else $error("dilution readback wrong");
cover property ($rose(PPS_OUT));
cover property (st_rd && HRDATA[15]);
cover property (mode_q == 2'h3);
endmodule // tsgps_sva
bind tsgps_top tsgps_sva #(.TICKS_PER_SEC(TICKS_PER_SEC)) tsgps_sva_inst (.CLK(CLK), .NRST(NRST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .HRDATA(HRDATA), .PPS_OUT(PPS_OUT), .TIME_SECONDS(TIME_SECONDS), .RTC_SECONDS(RTC_SECONDS),
    .GPS_LOCK(GPS_LOCK), .GPS_DILUTION(GPS_DILUTION), .GPS_SATS_VIEW(GPS_SATS_VIEW), .GPS_SATS_USED(GPS_SATS_USED));

// [sim/tsgps_src.sv]
`timescale 1ns/100ps
module tsgps_src (
    input wire clk, // clock
    output reg [31:0] gsec, // fix time
    output reg gvld, // time pulse
    output reg glock, // lock
    output reg [15:0] gdil, // dilution
    output reg [3:0] gview, // in view
    output reg [3:0] gused, // in use
    output reg [31:0] isec, // frame time
    output reg [17:0] icf, // control field
    output reg ivld // frame pulse
);
// ----
// receiver and frame source
// ----
// receiver and frame time references only, no second pulse input is offered
initial begin
    {gsec, gvld, glock, gdil, gview, gused, isec, icf, ivld} = 0;
end
task fix(input l, input [15:0] d, input [3:0] v, input [3:0] u);
    @(posedge clk);
    {glock, gdil, gview, gused} <= {l, d, v, u};
endtask
// stale time after the pulse is inverted so a late sample is caught
task gtime(input [31:0] s);
    @(posedge clk);
    {gsec, gvld} <= {s, 1'b1};
    @(posedge clk);
    {gsec, gvld} <= {~s, 1'b0};
endtask
task frame(input [31:0] s, input [17:0] c);
    @(posedge clk);
    {isec, icf, ivld} <= {s, c, 1'b1};
    @(posedge clk);
    {isec, icf, ivld} <= {~s, ~c, 1'b0};
endtask
endmodule // tsgps_src

// [sim/tsgps_tb_top.sv]
`timescale 1ns/100ps
module tsgps_tb_top;
// ----
// wiring
// ----
localparam T = 100;
reg clk, nrst, hsel, hwrite, p;
reg [1:0] htrans;
reg [31:0] haddr, hwdata, rtc, sd, q, g, ex, ye;
reg [15:0] d;
wire hrdy, hresp, irq, pps, gvld, glock, ivld;
wire [31:0] hrdata, tsec, gsec, isec;
wire [15:0] gdil;
wire [3:0] gview, gused;
wire [17:0] icf;
integer err_count, compares, i, n;
tsgps_top #(.TICKS_PER_SEC(T), .PPS_WIDTH(10)) tsgps_top_inst (.CLK(clk), .NRST(nrst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
    .HREADYOUT(hrdy), .HRESP(hresp), .HRDATA(hrdata), .IRQ(irq), .RTC_SECONDS(rtc), .GPS_SECONDS(gsec),
    .GPS_TIME_VALID(gvld), .GPS_LOCK(glock), .GPS_DILUTION(gdil), .GPS_SATS_VIEW(gview), .GPS_SATS_USED(gused),
    .IRIG_SECONDS(isec), .IRIG_CONTROL_FUNCTION_BITS(icf), .IRIG_FRAME_VALID(ivld), .PPS_OUT(pps), .TIME_SECONDS(tsec));
tsgps_src tsgps_src_inst (.clk(clk), .gsec(gsec), .gvld(gvld), .glock(glock), .gdil(gdil), .gview(gview),
    .gused(gused), .isec(isec), .icf(icf), .ivld(ivld));
initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
end
function [31:0] lf(input [31:0] x);
    lf = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction
// bcd digits above nine are clamped
function [31:0] yr(input [17:0] c);
    yr = (c[8:5] > 9 ? 9 : c[8:5]) * 10 + (c[3:0] > 9 ? 9 : c[3:0]);
endfunction
task close_out;
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error %0t got %h exp %h", $time, got, exp);
    end
endtask
// bounded wait for hready at a rising edge
task rdy;
    integer m;
    m = 0;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
        m = m + 1;
        if (m > 20) begin
            err_count = err_count + 1;
            close_out;
        end
        @(posedge clk);
    end
endtask
task xfer(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
    {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'h2, w};
    rdy;
    {htrans, hwdata} <= {2'h0, wd};
    rdy;
    rd = hrdata;
endtask
// ----
// main sequence
// ----
initial begin
    {err_count, compares} = 0;
    sd = lf(32'd74265);
    {rtc, nrst, hsel, haddr, htrans, hwrite, hwdata} <= {sd, 69'h0};
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    xfer(0, 8'h10, 0, q); chk(q, rtc);
    xfer(0, 8'h18, 0, q); chk(q & 32'h8, 32'h8);
    xfer(1, 8'h1C, 32'h8, q); @(posedge clk); chk({31'h0, irq}, 1);
    xfer(1, 8'h18, 32'h8, q); @(posedge clk); chk({31'h0, irq}, 0);
    xfer(1, 8'h1C, 0, q);
    sd = lf(sd); src_time(sd);
    xfer(0, 8'h10, 0, q); chk({31'h0, q === rtc || q === rtc + 1}, 1);
    xfer(1, 8'h00, 1, q); tsgps_src_inst.gtime(sd);
    xfer(0, 8'h10, 0, q); chk(q, sd);
    chk(tsec, sd);
    xfer(1, 8'h00, 3, q);
    for (i = 0; i < 5; i = i + 1) begin
        sd = lf(sd);
        g = i == 0 ? 32'h3FFFF : sd;
        tsgps_src_inst.frame(sd, g[17:0]);
        ye = yr(g[17:0]);
        xfer(0, 8'h14, 0, q); chk(q, ye);
    end
    xfer(1, 8'h00, 2, q); tsgps_src_inst.frame(sd, 18'h21);
    xfer(0, 8'h14, 0, q); chk(q, ye);
    for (i = 0; i < 8; i = i + 1) begin
        sd = lf(sd);
        d = i < 2 ? 16'h5 + i : sd[15:0];
        tsgps_src_inst.fix(sd[16], d, sd[23:20], sd[27:24]);
        repeat (3) @(posedge clk);
        ex = {16'h0, sd[16], 3'h0, d > 16'h5, 3'h0, sd[23:20], sd[27:24]};
        xfer(0, 8'h04, 0, q); chk(q, ex);
        xfer(0, 8'h08, 0, q); chk(q, {16'h0, d});
    end
    xfer(1, 8'h04, 32'hFFFFFFFF, q); xfer(0, 8'h04, 0, q); chk(q, ex);
    xfer(1, 8'h00, 0, q);
    {n, p} = 0;
    repeat (3 * T) begin
        @(negedge clk);
        if (pps && !p) n = n + 1;
        p = pps;
    end
    chk(n, 3);
    close_out;
end
// gps and irig both active while rtc is selected
task src_time(input [31:0] s);
    tsgps_src_inst.fix(1'b1, 16'h3, 4'h5, 4'h4);
    tsgps_src_inst.gtime(s);
    tsgps_src_inst.frame(s, 18'h0);
endtask
endmodule // tsgps_tb_top
